// >>> rtl/lcd_host_pkg.sv
/*
  shared constants and types of the lcd host pin interface.
  assumes a 100 MHz i_ref_clk; times below are in ns.
*/
package lcd_host_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_WINDOW_NS = 2000;
  localparam int OSC_WINDOW_CYC = OSC_WINDOW_NS / CLK_PERIOD_NS;
  localparam int EXT_SHIFT_HALF_NS = 100;
  localparam int EXT_SHIFT_HALF_CYC = (EXT_SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_LATCH_NS = 200;
  localparam int EXT_LATCH_CYC = (EXT_LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_DOTS_DEFAULT = 40;
  // ==========================================================
  // host port fields
  localparam logic [4:0] SER_SYNC_PATTERN = 5'h1f;
  localparam int SER_SYNC_RW_POS = 2;
  localparam int SER_SYNC_RS_POS = 1;
  localparam logic [2:0] FUNC_SET_OPCODE = 3'h1;
  localparam int FUNC_SET_DL_POS = 4;
  localparam logic DL_RESET = 1'h1;
  localparam logic [7:0] RELEASE_ALL = 8'hff;
  localparam logic [7:0] DRIVE_ALL = 8'h00;
  localparam logic [7:0] DRIVE_HIGH_NIBBLE = 8'h0f;
  localparam logic [7:0] DRIVE_SERIAL_OUT = 8'hfe;
  localparam int PIN_SYNC_WIDTH = 15;
  // ==========================================================
  // serial receiver states
  typedef enum logic [3:0] {
    SER_SYNC = 4'b0001,
    SER_HI = 4'b0010,
    SER_LO = 4'b0100,
    SER_READ = 4'b1000
  } serial_state_t;
endpackage

// >>> rtl/pin_sync2.sv
/*
  two-flop synchroniser for a group of pin levels.
  assumes each bit is a level from outside the i_ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  initial begin
    if (WIDTH < 1) $error("pin_sync2: WIDTH must be at least 1");
  end
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;
  sync_state_t st_r;
  sync_state_t st_nxt;
  always_comb begin
    st_nxt.meta = i_async;
    st_nxt.stable = st_r.meta;
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_sync = st_r.stable;
endmodule
`default_nettype wire

// >>> rtl/ext_dot_shifter.sv
/*
  extension driver feed: shift clock, latch clock, ac signal, dot data.
  assumes line and frame starts are one-cycle pulses on i_ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ext_dot_shifter
  import lcd_host_pkg::*;
#(
  parameter int DOTS = EXT_DOTS_DEFAULT
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic i_line_start,
  input wire logic i_frame_start,
  input wire logic [DOTS-1:0] i_dots,
  output logic o_shift_clk,
  output logic o_latch_clk,
  output logic o_ac,
  output logic o_dot
);
  localparam int CW = $clog2(DOTS + 1);
  initial begin
    if (DOTS < 2) $error("ext_dot_shifter: DOTS must be at least 2");
    if (EXT_SHIFT_HALF_CYC > 255 || EXT_LATCH_CYC > 255) $error("ext_dot_shifter: divider too wide");
  end
  typedef struct packed {
    logic busy;
    logic [DOTS-1:0] dots;
    logic [CW-1:0] left;
    logic [7:0] div;
    logic phase;
    logic shift_clk;
    logic latch_clk;
    logic ac;
    logic dot;
  } ext_state_t;
  ext_state_t st_r;
  ext_state_t st_nxt;
  // ==========================================================
  // shifter
  always_comb begin
    logic [DOTS-1:0] rest;
    rest = st_r.dots >> 1;
    st_nxt = st_r;
    if (!i_enable) begin
      st_nxt = '0;
    end else begin
      if (i_frame_start) st_nxt.ac = ~st_r.ac;
      if (st_r.latch_clk) begin
        if (st_r.div == 8'h00) st_nxt.latch_clk = 1'b0;
        else st_nxt.div = st_r.div - 8'h01;
      end else if (!st_r.busy && i_line_start) begin
        st_nxt.busy = 1'b1;
        st_nxt.dots = i_dots;
        st_nxt.left = CW'(DOTS);
        st_nxt.div = 8'(EXT_SHIFT_HALF_CYC - 1);
        st_nxt.phase = 1'b0;
        st_nxt.dot = i_dots[0];
      end else if (st_r.busy) begin
        if (st_r.div != 8'h00) begin
          st_nxt.div = st_r.div - 8'h01;
        end else begin
          st_nxt.div = 8'(EXT_SHIFT_HALF_CYC - 1);
          st_nxt.phase = ~st_r.phase;
          st_nxt.shift_clk = ~st_r.phase;
          if (st_r.phase) begin
            st_nxt.dots = rest;
            st_nxt.dot = rest[0];
            st_nxt.left = st_r.left - CW'(1);
            if (st_r.left == CW'(1)) begin
              st_nxt.busy = 1'b0;
              st_nxt.dot = 1'b0;
              st_nxt.latch_clk = 1'b1;
              st_nxt.div = 8'(EXT_LATCH_CYC - 1);
            end
          end
        end
      end
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_shift_clk = st_r.shift_clk;
  assign o_latch_clk = st_r.latch_clk;
  assign o_ac = st_r.ac;
  assign o_dot = st_r.dot;
  // ==========================================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  AST_EXT_QUIET: assert property (!i_enable |=> !o_shift_clk && !o_latch_clk && !o_ac && !o_dot)
    else $error("extension outputs active while disabled");
  AST_EXT_LATCH_AFTER_LAST: assert property ($rose(o_latch_clk) |-> st_r.left == '0 && !st_r.busy)
    else $error("latch clock before last dot");
  AST_EXT_AC_TOGGLE: assert property (i_enable && i_frame_start |=> o_ac != $past(o_ac))
    else $error("ac signal did not alternate");
  AST_EXT_FIRST_DOT: assert property (i_enable && i_line_start && !st_r.busy && !st_r.latch_clk
    |=> o_dot == $past(i_dots[0]) ##0 !o_shift_clk [*2])
    else $error("first extension dot wrong");
endmodule
`default_nettype wire

// >>> rtl/lcd_host_port.sv
/*
  host pin interface of a character lcd controller: serial or 4/8-bit bus,
  busy flag on the top data bit, extension driver outputs, clock source sense.
  assumes all pins are asynchronous to i_ref_clk; core side is on i_ref_clk.
*/
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - interface select low gives serial mode, high gives parallel bus mode.
// - in bus mode register select high picks data, low picks instruction.
// - in serial mode register select is an active-low chip select.
// - in bus mode direction high reads, low writes.
// - in serial mode the direction pin carries serial input data.
// - in bus mode the strobe qualifies each transfer.
// - in serial mode the strobe pin is the host serial clock.
// - serial read data leaves on bit 0; in 8-bit mode it is data bit 0.
// - bits one to three are data only in 8-bit mode.
// - bits four to seven carry both nibbles in 4-bit, high nibble in 8-bit.
// - busy flag appears on bit 7 during a status read.
// - expansion strap low keeps extension outputs inactive.
// - with expansion on, latch and shift clocks are produced.
// - with expansion on, the ac alternation signal is produced.
// - with expansion on, extension dots shift out serially, first beyond own segments.
// - instruction set variant follows the instruction set strap.
// - external clock on the oscillator pin is used when present.
// - bus width bit of function set picks 4-bit or 8-bit transfers.
// - select and direction decode to instruction write, status read, data write, data read.
module lcd_host_port
  import lcd_host_pkg::*;
#(
  parameter int EXT_DOTS = EXT_DOTS_DEFAULT
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_interface_select_pin,
  input wire logic i_register_or_chip_select,
  input wire logic i_direction_or_serial_in,
  input wire logic i_strobe_or_serial_clock,
  input wire logic [7:0] i_bus_data,
  output logic [7:0] o_bus_data,
  output logic [7:0] o_bus_data_oe_b,
  input wire logic i_expansion_enable,
  input wire logic i_instruction_set_select,
  input wire logic i_oscillator_input,
  input wire logic i_busy_flag,
  input wire logic [6:0] i_address_counter,
  input wire logic [7:0] i_read_data,
  input wire logic i_line_start,
  input wire logic i_frame_start,
  input wire logic [EXT_DOTS-1:0] i_ext_dots,
  output logic o_instr_valid,
  output logic [7:0] o_instr_code,
  output logic o_data_wr_valid,
  output logic [7:0] o_data_wr,
  output logic o_data_rd_advance,
  output logic o_bus_width_8bit,
  output logic o_instruction_set_variant,
  output logic o_external_clock_active,
  output logic o_expansion_latch_clock,
  output logic o_expansion_shift_clock,
  output logic o_ac_alternation_signal,
  output logic o_extension_pixel_out
);
  initial begin
    if (OSC_WINDOW_CYC < 2 || OSC_WINDOW_CYC > 4096) $error("lcd_host_port: oscillator window out of range");
  end
  // ==========================================================
  // pin synchronisers
  logic [PIN_SYNC_WIDTH-1:0] pins_s;
  pin_sync2 #(
    .WIDTH(PIN_SYNC_WIDTH)
  ) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_oscillator_input, i_instruction_set_select, i_expansion_enable, i_interface_select_pin,
      i_register_or_chip_select, i_direction_or_serial_in, i_strobe_or_serial_clock, i_bus_data}),
    .o_sync(pins_s)
  );
  logic osc_s, ie_s, ext_s, im_s, rs_s, rw_s, e_s;
  logic [7:0] db_s;
  assign {osc_s, ie_s, ext_s, im_s, rs_s, rw_s, e_s, db_s} = pins_s;
  // ==========================================================
  // state
  typedef struct packed {
    logic e_d;
    logic osc_d;
    logic [11:0] osc_cnt;
    logic osc_ext;
    logic ie;
    logic dl;
    logic nib_lo;
    logic [7:0] held;
    logic [7:0] bus_out;
    logic [7:0] oe_b;
    logic instr_valid;
    logic [7:0] instr_code;
    logic data_wr_valid;
    logic [7:0] data_wr;
    logic rd_advance;
    serial_state_t ser_state;
    logic [7:0] ser_shift;
    logic [2:0] ser_cnt;
    logic ser_rs;
    logic [3:0] ser_hi;
  } port_state_t;
  port_state_t st_r;
  port_state_t st_nxt;
  // status read or data read byte
  function automatic logic [7:0] read_byte(input logic rs, input logic busy, input logic [6:0] ac,
    input logic [7:0] dat);
    read_byte = rs ? dat : {busy, ac};
  endfunction
  logic e_rise, e_fall;
  assign e_rise = e_s && !st_r.e_d;
  assign e_fall = !e_s && st_r.e_d;
  // ==========================================================
  // next state
  always_comb begin
    logic wr_go;
    logic wr_rs;
    logic [7:0] wr_byte;
    logic [7:0] rd;
    logic [7:0] sh;
    wr_go = 1'b0;
    wr_rs = 1'b0;
    wr_byte = 8'h00;
    rd = read_byte(rs_s, i_busy_flag, i_address_counter, i_read_data);
    sh = {st_r.ser_shift[6:0], rw_s};
    st_nxt = st_r;
    st_nxt.e_d = e_s;
    st_nxt.osc_d = osc_s;
    st_nxt.ie = ie_s;
    st_nxt.instr_valid = 1'b0;
    st_nxt.data_wr_valid = 1'b0;
    st_nxt.rd_advance = 1'b0;
    // clock source sense
    if (osc_s != st_r.osc_d) begin
      st_nxt.osc_cnt = 12'h000;
      st_nxt.osc_ext = 1'b1;
    end else if (st_r.osc_cnt == 12'(OSC_WINDOW_CYC - 1)) begin
      st_nxt.osc_ext = 1'b0;
    end else begin
      st_nxt.osc_cnt = st_r.osc_cnt + 12'h001;
    end
    if (im_s) begin
      st_nxt.ser_state = SER_SYNC;
      st_nxt.ser_cnt = 3'h0;
      if (e_rise && rw_s) begin
        if (st_r.dl) begin
          st_nxt.bus_out = rd;
          st_nxt.oe_b = DRIVE_ALL;
        end else if (!st_r.nib_lo) begin
          st_nxt.held = rd;
          st_nxt.bus_out = {rd[7:4], 4'h0};
          st_nxt.oe_b = DRIVE_HIGH_NIBBLE;
        end else begin
          st_nxt.bus_out = {st_r.held[3:0], 4'h0};
          st_nxt.oe_b = DRIVE_HIGH_NIBBLE;
        end
      end
      if (e_fall) begin
        st_nxt.oe_b = RELEASE_ALL;
        if (!st_r.dl) st_nxt.nib_lo = ~st_r.nib_lo;
        if (st_r.dl || st_r.nib_lo) begin
          if (rw_s) begin
            st_nxt.rd_advance = rs_s;
          end else begin
            wr_go = 1'b1;
            wr_rs = rs_s;
            wr_byte = st_r.dl ? db_s : {st_r.held[7:4], db_s[7:4]};
          end
        end else if (!rw_s) begin
          st_nxt.held = {db_s[7:4], 4'h0};
        end
      end
    end else begin
      st_nxt.nib_lo = 1'b0;
      if (rs_s) begin
        st_nxt.ser_state = SER_SYNC;
        st_nxt.ser_cnt = 3'h0;
        st_nxt.oe_b = RELEASE_ALL;
      end else begin
        case (st_r.ser_state)
          SER_SYNC: begin
            if (e_rise) begin
              st_nxt.ser_shift = sh;
              if (sh[7:3] == SER_SYNC_PATTERN && !sh[0]) begin
                st_nxt.ser_rs = sh[SER_SYNC_RS_POS];
                st_nxt.ser_cnt = 3'h0;
                if (sh[SER_SYNC_RW_POS]) begin
                  st_nxt.ser_state = SER_READ;
                  st_nxt.held = read_byte(sh[SER_SYNC_RS_POS], i_busy_flag, i_address_counter, i_read_data);
                  st_nxt.bus_out = {7'h00, st_nxt.held[7]};
                  st_nxt.oe_b = DRIVE_SERIAL_OUT;
                end else begin
                  st_nxt.ser_state = SER_HI;
                end
              end
            end
          end
          SER_HI, SER_LO: begin
            if (e_rise) begin
              st_nxt.ser_shift = sh;
              st_nxt.ser_cnt = st_r.ser_cnt + 3'h1;
              if (st_r.ser_cnt == 3'h7) begin
                if (st_r.ser_state == SER_HI) begin
                  st_nxt.ser_hi = sh[7:4];
                  st_nxt.ser_state = SER_LO;
                end else begin
                  wr_go = 1'b1;
                  wr_rs = st_r.ser_rs;
                  wr_byte = {st_r.ser_hi, sh[7:4]};
                  st_nxt.ser_state = SER_HI;
                end
              end
            end
          end
          SER_READ: begin
            if (e_fall) begin
              st_nxt.ser_cnt = st_r.ser_cnt + 3'h1;
              st_nxt.held = {st_r.held[6:0], 1'b0};
              st_nxt.bus_out = {7'h00, st_r.held[6]};
              if (st_r.ser_cnt == 3'h7) begin
                st_nxt.ser_state = SER_SYNC;
                st_nxt.bus_out = 8'h00;
                st_nxt.oe_b = RELEASE_ALL;
                st_nxt.rd_advance = st_r.ser_rs;
              end
            end
          end
          default: begin
            st_nxt.ser_state = SER_SYNC;
          end
        endcase
      end
    end
    // write commit, shared by both modes
    if (wr_go) begin
      if (wr_rs) begin
        st_nxt.data_wr_valid = 1'b1;
        st_nxt.data_wr = wr_byte;
      end else if (!i_busy_flag) begin
        st_nxt.instr_valid = 1'b1;
        st_nxt.instr_code = wr_byte;
        if (wr_byte[7:5] == FUNC_SET_OPCODE) begin
          st_nxt.dl = wr_byte[FUNC_SET_DL_POS];
          st_nxt.nib_lo = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      st_r <= '{ser_state: SER_SYNC, oe_b: RELEASE_ALL, dl: DL_RESET, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end
  // ==========================================================
  // extension driver
  ext_dot_shifter #(
    .DOTS(EXT_DOTS)
  ) u_ext (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_enable(ext_s),
    .i_line_start(i_line_start),
    .i_frame_start(i_frame_start),
    .i_dots(i_ext_dots),
    .o_shift_clk(o_expansion_shift_clock),
    .o_latch_clk(o_expansion_latch_clock),
    .o_ac(o_ac_alternation_signal),
    .o_dot(o_extension_pixel_out)
  );
  // ==========================================================
  // outputs
  assign o_bus_data = st_r.bus_out;
  assign o_bus_data_oe_b = st_r.oe_b;
  assign o_instr_valid = st_r.instr_valid;
  assign o_instr_code = st_r.instr_code;
  assign o_data_wr_valid = st_r.data_wr_valid;
  assign o_data_wr = st_r.data_wr;
  assign o_data_rd_advance = st_r.rd_advance;
  assign o_bus_width_8bit = st_r.dl;
  assign o_instruction_set_variant = st_r.ie;
  assign o_external_clock_active = st_r.osc_ext;
  // ==========================================================
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_nib_first_write;
    im_s && e_fall && !rw_s && !st_r.dl && !st_r.nib_lo;
  endsequence
  sequence s_serial_read_start;
    !im_s && !rs_s && st_r.ser_state == SER_SYNC && e_rise && {st_r.ser_shift[6:0], rw_s} ==? 8'b11111_1?0;
  endsequence
  AST_SERIAL_KEEPS_BUS_OFF: assert property (!im_s |=> o_bus_data_oe_b[7:1] == 7'h7f)
    else $error("parallel lines driven in serial mode");
  AST_PAR_DATA_WRITE: assert property (im_s && e_fall && !rw_s && rs_s && st_r.dl
    |=> o_data_wr_valid && o_data_wr == $past(db_s) && !o_instr_valid)
    else $error("8-bit data write not delivered");
  AST_CS_DESELECT: assert property (!im_s && rs_s |=> st_r.ser_state == SER_SYNC && o_bus_data_oe_b[0])
    else $error("deselected serial port still active");
  AST_PAR_READ_DRIVE: assert property (im_s && e_rise && rw_s && st_r.dl |=> o_bus_data_oe_b == DRIVE_ALL)
    else $error("8-bit read not driven");
  AST_BUSY_ON_TOP_BIT: assert property (im_s && e_rise && rw_s && !rs_s && !st_r.nib_lo
    |=> o_bus_data[7] == $past(i_busy_flag))
    else $error("busy flag missing on bit 7");
  AST_SERIAL_READ_FIRST_BIT: assert property (s_serial_read_start
    |=> !o_bus_data_oe_b[0] && st_r.ser_state == SER_READ)
    else $error("serial read did not start");
  AST_NIBBLE_ORDER: assert property (s_nib_first_write |=> st_r.nib_lo && !o_data_wr_valid && !o_instr_valid)
    else $error("first nibble committed early");
  AST_RELEASE_AFTER_STROBE: assert property (im_s && e_fall |=> o_bus_data_oe_b == RELEASE_ALL)
    else $error("bus not released after strobe");
  AST_NO_INSTR_WHILE_BUSY: assert property (o_instr_valid |-> $past(!i_busy_flag))
    else $error("instruction taken while busy");
  AST_DL_FOLLOWS_FUNC_SET: assert property (o_instr_valid && o_instr_code[7:5] == FUNC_SET_OPCODE
    |-> o_bus_width_8bit == o_instr_code[FUNC_SET_DL_POS])
    else $error("bus width bit not updated");
  AST_OSC_EDGE_SELECTS_EXT: assert property (osc_s != st_r.osc_d |=> o_external_clock_active)
    else $error("external clock not detected");
  AST_IE_FOLLOWS_STRAP: assert property (##1 o_instruction_set_variant == $past(ie_s))
    else $error("instruction set variant stale");
endmodule
`default_nettype wire

// >>> tb/lcd_host_mpu.sv
/*
  host microprocessor model: drives the shared pins in bus or serial mode.
  assumes the bench resolves the data pins from both enables.
*/
`timescale 1ns/1ps
`default_nettype none
module lcd_host_mpu (
  input wire logic i_ref_clk,
  input wire logic [7:0] i_pins,
  input wire logic [7:0] i_oe_b,
  output logic o_im,
  output logic o_rs,
  output logic o_rw,
  output logic o_e,
  output logic o_drv,
  output logic [7:0] o_d
);
  initial begin
    o_im = 1'b1;
    o_rs = 1'b1;
    o_rw = 1'b0;
    o_e = 1'b0;
    o_drv = 1'b0;
    o_d = 8'h00;
  end
  // ==========================================================
  // bus cycles
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic set_im(input logic m);
    o_im <= m;
    o_rs <= 1'b1;
  endtask
  task automatic bus(input logic rs, input logic rw, input logic [7:0] d, output logic [15:0] q);
    o_rs <= rs;
    o_rw <= rw;
    o_d <= d;
    o_drv <= ~rw;
    o_e <= 1'b1;
    cyc(6);
    q = {i_oe_b, i_pins};
    o_e <= 1'b0;
    cyc(6);
    o_drv <= 1'b0;
    cyc(1);
  endtask
  // ==========================================================
  // serial frames, 80 ns clock, msb first
  task automatic sbit(input logic b, output logic s);
    s = i_pins[0];
    o_e <= 1'b0;
    o_rw <= b;
    cyc(4);
    o_e <= 1'b1;
    cyc(4);
  endtask
  task automatic sfr(input logic [23:0] bits, input int n, output logic [7:0] q);
    o_rs <= 1'b0;
    cyc(4);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) sbit(bits[23 - 8 * k - 7 + i], q[i]);
    end
    o_e <= 1'b0;
    cyc(4);
    o_rs <= 1'b1;
    cyc(4);
  endtask
endmodule
`default_nettype wire

// >>> tb/test_lcd_host_port.sv
/*
  self-checking bench of the lcd host pin interface.
  assumes the host model in lcd_host_mpu and the design package.
*/
`timescale 1ns/1ps
`default_nettype none
module test_lcd_host_port;
  import lcd_host_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic busy = 1'b0, sel = 1'b0, osc = 1'b0, osc_run = 1'b0, ext = 1'b0, ls = 1'b0, fs = 1'b0;
  logic [6:0] ac = 7'h00;
  logic [7:0] rdat = 8'h00, pins, hd, od, oe_b, ic, wd, q8, last_i, last_w, sh;
  logic im, rs, rw, e, drv, iv, wv, ra, bw, var_o, xc, lc, sc, acs, px, a0;
  logic flt = 1'b0, sc_q = 1'b0, lc_q = 1'b0;
  logic [15:0] q;
  int num_errors = 0, comparisons = 0, n_i = 0, n_w = 0, n_r = 0, n_s = 0, n_l = 0;
  initial forever #5 i_ref_clk = ~i_ref_clk;
  always #40 if (osc_run) osc = ~osc;
  // released lines show a pattern that changes every cycle
  assign pins = drv ? hd : (od & ~oe_b) | ({8{flt}} & oe_b);
  lcd_host_mpu h (.i_ref_clk(i_ref_clk), .i_pins(pins), .i_oe_b(oe_b), .o_im(im), .o_rs(rs),
    .o_rw(rw), .o_e(e), .o_drv(drv), .o_d(hd));
  lcd_host_port #(.EXT_DOTS(8)) dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_interface_select_pin(im), .i_register_or_chip_select(rs), .i_direction_or_serial_in(rw),
    .i_strobe_or_serial_clock(e), .i_bus_data(pins), .o_bus_data(od), .o_bus_data_oe_b(oe_b),
    .i_expansion_enable(ext), .i_instruction_set_select(sel), .i_oscillator_input(osc),
    .i_busy_flag(busy), .i_address_counter(ac), .i_read_data(rdat), .i_line_start(ls),
    .i_frame_start(fs), .i_ext_dots(8'hb4), .o_instr_valid(iv), .o_instr_code(ic),
    .o_data_wr_valid(wv), .o_data_wr(wd), .o_data_rd_advance(ra), .o_bus_width_8bit(bw),
    .o_instruction_set_variant(var_o), .o_external_clock_active(xc),
    .o_expansion_latch_clock(lc), .o_expansion_shift_clock(sc),
    .o_ac_alternation_signal(acs), .o_extension_pixel_out(px));
  // ==========================================================
  // pulse and extension monitors
  always_ff @(posedge i_ref_clk) begin
    flt <= ~flt;
    sc_q <= sc;
    lc_q <= lc;
    if (iv === 1'b1) begin
      n_i <= n_i + 1;
      last_i <= ic;
    end
    if (wv === 1'b1) begin
      n_w <= n_w + 1;
      last_w <= wd;
    end
    if (ra === 1'b1) n_r <= n_r + 1;
    if (sc === 1'b1 && sc_q === 1'b0) begin
      n_s <= n_s + 1;
      sh <= {px, sh[7:1]};
    end
    if (lc === 1'b1 && lc_q === 1'b0) n_l <= n_l + 1;
  end
  // ==========================================================
  // checking and closing
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    cyc(10);
    i_rst_b <= 1'b1;
    cyc(2);
    chk("reset", 16'hff80, {oe_b, bw, lc, sc, acs, px, 3'h0});
    h.bus(1'b1, 1'b0, 8'ha5, q);
    chk("dwr", 16'h01a5, {n_w[7:0], last_w});
    chk("idle", 8'hff, oe_b);
    h.bus(1'b0, 1'b0, 8'h3c, q);
    chk("iwr", 16'h013c, {n_i[7:0], last_i});
    busy <= 1'b1;
    ac <= 7'h2b;
    h.bus(1'b0, 1'b1, 8'h00, q);
    chk("stat", 16'h00ab, q);
    h.bus(1'b0, 1'b0, 8'h3d, q);
    chk("busywr", 16'h013c, {n_i[7:0], last_i});
    busy <= 1'b0;
    rdat <= 8'h5a;
    h.bus(1'b1, 1'b1, 8'h00, q);
    chk("drd", 16'h005a, q);
    chk("adv", 1, n_r);
    $display("test bus8 done");
    h.bus(1'b0, 1'b0, 8'h20, q);
    chk("width4", 16'h0220, {n_i[7:0], last_i[7:1], bw});
    h.bus(1'b1, 1'b0, 8'hc0, q);
    h.bus(1'b1, 1'b0, 8'h30, q);
    chk("d4", 16'h02c3, {n_w[7:0], last_w});
    rdat <= 8'h96;
    h.bus(1'b1, 1'b1, 8'h00, q);
    chk("r4hi", 12'h0f9, q[15:4]);
    h.bus(1'b1, 1'b1, 8'h00, q);
    chk("r4lo", 12'h0f6, q[15:4]);
    $display("test bus4 done");
    h.set_im(1'b0);
    cyc(6);
    h.sfr(24'hfa9060, 3, q8);
    chk("swr", 16'h0396, {n_w[7:0], last_w});
    rdat <= 8'hc5;
    h.sfr(24'hfe0000, 2, q8);
    chk("srd", 8'hc5, q8);
    chk("srel", 8'hff, oe_b);
    $display("test serial done");
    sel <= 1'b1;
    osc_run <= 1'b1;
    cyc(60);
    chk("straps", 2'h3, {var_o, xc});
    osc_run <= 1'b0;
    sel <= 1'b0;
    cyc(260);
    chk("internal", 2'h0, {var_o, xc});
    $display("test straps done");
    ext <= 1'b1;
    cyc(6);
    ls <= 1'b1;
    cyc(1);
    ls <= 1'b0;
    for (int i = 0; i < 1000 && n_l == 0; i++) cyc(1);
    chk("latch", 1, n_l);
    if (n_l == 0) tally_and_finish;
    chk("dots", 16'h08b4, {n_s[7:0], sh});
    a0 = acs;
    fs <= 1'b1;
    cyc(1);
    fs <= 1'b0;
    cyc(3);
    chk("ac", {15'h0000, !a0}, acs);
    ext <= 1'b0;
    cyc(6);
    chk("off", 4'h0, {lc, sc, acs, px});
    $display("test expansion done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
